// ### serial_slave_framer.sv
// slave-side query framer, dispatcher and reply builder for binary and character modes
//Contract
//- binary mode frames are bounded by at least 3.5 character times of silence
//- binary mode carries raw bytes protected by a cyclic check field
//- character mode uses start and end characters and a longitudinal check
//- only the configured mode is decoded; other framing never yields a valid query
//- the slave transmits only in answer to a received query
//- address zero is broadcast: acted on, never answered
//- normal reply echoes address and function, then byte count, data, check
//- only own address within one to 247 is answered
//- read functions one to four are decoded
//- frames with check or reception errors are dropped without reply
//- unserviceable valid queries get an exception reply
`timescale 1ns/1ns
module serial_slave_framer (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ascii_mode,
  input  wire logic [7:0]  own_addr,
  input  wire logic [15:0] bit_cycles,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_err,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic             q_valid,
  output logic             q_bcast,
  output logic      [7:0]  q_func,
  output logic      [15:0] q_start,
  output logic      [15:0] q_count,
  input  wire logic [7:0]  data_byte,
  input  wire logic        data_valid,
  output logic             data_ready,
  output logic             rx_drop,
  output logic             tx_busy
);
  typedef enum logic [2:0] {T_IDLE, T_COLON, T_LOAD, T_SEND, T_CR, T_LF, T_GAP} tx_state_t;

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ serial_slave_pkg::CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'hA) ? serial_slave_pkg::ASC_ZERO + {4'h0, n} : serial_slave_pkg::ASC_A_OFS + {4'h0, n};
  endfunction

  tx_state_t   tx_st_reg;
  logic        in_frame_reg, cr_seen_reg, err_reg, anib_reg, tnib_reg, exc_reg;
  logic [3:0]  nib_reg;
  logic [7:0]  idx_reg, addr_reg, fn_reg, lrc_reg;
  logic [15:0] crc_reg, start_reg, cnt_reg, tcrc_reg;
  logic [23:0] quiet_reg;
  logic [7:0]  taddr_reg, tfn_reg, tb2_reg, body_len_reg, pos_reg, cur_reg, tlrc_reg;

  // silence threshold from the bit period; 3.5 chars of 11 bits each
  wire [23:0] gap_cycles = 24'((24'(bit_cycles) * serial_slave_pkg::GAP_FACTOR) >> 1);
  wire        quiet_done = quiet_reg >= gap_cycles;

  // receive decode: bytes are ignored while a reply is in progress (half duplex)
  wire       rx_take = rx_valid && (tx_st_reg == T_IDLE);
  wire       is_dig  = rx_data >= serial_slave_pkg::ASC_ZERO && rx_data <= serial_slave_pkg::ASC_NINE;
  wire       is_let  = rx_data >= serial_slave_pkg::ASC_UA && rx_data <= serial_slave_pkg::ASC_UF;
  wire       hex_ok  = is_dig || is_let;
  wire [7:0] let_val = rx_data - serial_slave_pkg::ASC_A_OFS;
  wire [3:0] hex_nib = is_dig ? rx_data[3:0] : let_val[3:0];
  wire a_start = ascii_mode && rx_take && rx_data == serial_slave_pkg::CHR_START;
  wire a_char  = ascii_mode && rx_take && in_frame_reg && !a_start;
  wire a_cr    = a_char && rx_data == serial_slave_pkg::CHR_CR;
  wire a_end   = a_char && cr_seen_reg && rx_data == serial_slave_pkg::CHR_LF;
  wire a_nib   = a_char && !cr_seen_reg && !a_cr;
  wire a_bad   = (a_nib && !hex_ok) || (a_char && cr_seen_reg && !a_end);
  wire b_take  = !ascii_mode && rx_take;
  wire b_end   = !ascii_mode && in_frame_reg && !rx_take && quiet_done;
  wire start   = a_start || (b_take && !in_frame_reg);
  wire frame_end = a_end || b_end;
  wire lb_valid  = b_take || (a_nib && hex_ok && anib_reg);
  wire [7:0] lb_data = ascii_mode ? {nib_reg, hex_nib} : rx_data;

  // a new start wipes any partial frame, so a restarted ':' resynchronises
  wire [7:0]  idx_base = start ? 8'h00 : idx_reg;
  wire [15:0] crc_base = start ? serial_slave_pkg::CRC_INIT : crc_reg;
  wire [7:0]  lrc_base = start ? 8'h00 : lrc_reg;
  wire        err_now  = (rx_take && rx_err && (in_frame_reg || start)) || a_bad ||
                         (lb_valid && idx_base == serial_slave_pkg::LEN_MAX);

  // frame acceptance
  wire chk_ok   = ascii_mode ? (lrc_reg == 8'h00 && !anib_reg) : (crc_reg == 16'h0000);
  wire len_ok   = idx_reg >= (ascii_mode ? serial_slave_pkg::MIN_LEN_CHR : serial_slave_pkg::MIN_LEN_BIN);
  wire frame_ok = frame_end && !err_reg && !err_now && chk_ok && len_ok;
  wire own_ok   = own_addr != serial_slave_pkg::BCAST_ADDR && own_addr <= serial_slave_pkg::ADDR_MAX;
  wire is_bcast = addr_reg == serial_slave_pkg::BCAST_ADDR;
  wire hit      = is_bcast || (own_ok && addr_reg == own_addr);
  wire good     = frame_ok && hit;
  wire fn_ok    = fn_reg >= serial_slave_pkg::FN_MIN && fn_reg <= serial_slave_pkg::FN_MAX;
  wire bit_fn   = fn_reg <= serial_slave_pkg::FN_BIT_MAX;
  wire [15:0] cnt_max = bit_fn ? serial_slave_pkg::MAX_BITS : serial_slave_pkg::MAX_REGS;
  wire full_len = idx_reg >= (ascii_mode ? serial_slave_pkg::READ_LEN_CHR : serial_slave_pkg::READ_LEN_BIN);
  wire val_ok   = cnt_reg != 16'h0000 && cnt_reg <= cnt_max && full_len;
  wire act      = good && fn_ok && val_ok;
  wire reply_go = good && !is_bcast && tx_st_reg == T_IDLE;
  wire [15:0] bit_bytes = (cnt_reg + 16'h0007) >> 3;
  wire [7:0]  byte_cnt  = bit_fn ? bit_bytes[7:0] : 8'(cnt_reg << 1);

  // receive accumulators and field capture in query order
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_frame_reg <= 1'b0;
      cr_seen_reg  <= 1'b0;
      err_reg      <= 1'b0;
      anib_reg     <= 1'b0;
      nib_reg      <= 4'h0;
      idx_reg      <= 8'h00;
      crc_reg      <= serial_slave_pkg::CRC_INIT;
      lrc_reg      <= 8'h00;
      addr_reg     <= 8'h00;
      fn_reg       <= 8'h00;
      start_reg    <= 16'h0000;
      cnt_reg      <= 16'h0000;
    end else begin
      if (start) begin
        in_frame_reg <= 1'b1;
        cr_seen_reg  <= 1'b0;
        anib_reg     <= 1'b0;
      end else if (frame_end) begin
        in_frame_reg <= 1'b0;
      end else if (a_cr) begin
        cr_seen_reg <= 1'b1;
      end else if (a_nib && hex_ok) begin
        anib_reg <= !anib_reg;
        nib_reg  <= hex_nib;
      end
      err_reg <= (start ? 1'b0 : err_reg) || err_now;
      if (start || lb_valid) begin
        idx_reg <= lb_valid ? idx_base + 8'h01 : idx_base;
        crc_reg <= lb_valid ? crc_upd(crc_base, lb_data) : crc_base;
        lrc_reg <= lb_valid ? lrc_base + lb_data : lrc_base;
      end
      if (lb_valid) begin
        case (idx_base)
          8'h00:   addr_reg <= lb_data;
          8'h01:   fn_reg <= lb_data;
          8'h02:   start_reg[15:8] <= lb_data;
          8'h03:   start_reg[7:0] <= lb_data;
          8'h04:   cnt_reg[15:8] <= lb_data;
          8'h05:   cnt_reg[7:0] <= lb_data;
          default: ;
        endcase
      end
    end
  end

  // query hand-off to the application; broadcasts are acted on too
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_valid <= 1'b0;
      q_bcast <= 1'b0;
      q_func  <= 8'h00;
      q_start <= 16'h0000;
      q_count <= 16'h0000;
      rx_drop <= 1'b0;
    end else begin
      q_valid <= act;
      rx_drop <= frame_end && !frame_ok;
      if (act) begin
        q_bcast <= is_bcast;
        q_func  <= fn_reg;
        q_start <= start_reg;
        q_count <= cnt_reg;
      end
    end
  end

  // transmit sequencing: body bytes, then check, then trailer or silence
  wire       slot_free = !tx_valid || tx_ready;
  wire       in_body   = pos_reg < body_len_reg;
  wire       need_data = in_body && pos_reg >= serial_slave_pkg::REPLY_HDR && !exc_reg;
  wire [7:0] chk_last  = ascii_mode ? body_len_reg : body_len_reg + 8'h01;
  wire       load_done = pos_reg > chk_last;
  wire       load_ok   = !load_done && (!need_data || data_valid);
  wire [7:0] body_byte = (pos_reg == 8'h00) ? taddr_reg :
                         (pos_reg == 8'h01) ? tfn_reg :
                         (pos_reg == 8'h02) ? tb2_reg : data_byte;
  wire [7:0] lrc_neg   = ~tlrc_reg + 8'h01;
  wire [7:0] chk_byte  = ascii_mode ? lrc_neg :
                         (pos_reg == body_len_reg) ? tcrc_reg[7:0] : tcrc_reg[15:8];
  wire [7:0] load_byte = in_body ? body_byte : chk_byte;
  wire [7:0] send_chr  = !ascii_mode ? cur_reg : hex_chr(tnib_reg ? cur_reg[3:0] : cur_reg[7:4]);
  wire [7:0] tx_chr    = (tx_st_reg == T_COLON) ? serial_slave_pkg::CHR_START :
                         (tx_st_reg == T_CR) ? serial_slave_pkg::CHR_CR :
                         (tx_st_reg == T_LF) ? serial_slave_pkg::CHR_LF : send_chr;
  wire       emit      = tx_st_reg == T_COLON || tx_st_reg == T_SEND || tx_st_reg == T_CR || tx_st_reg == T_LF;
  wire       push      = emit && slot_free;
  assign data_ready = (tx_st_reg == T_LOAD) && need_data;
  assign tx_busy    = tx_st_reg != T_IDLE;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_reg    <= T_IDLE;
      taddr_reg    <= 8'h00;
      tfn_reg      <= 8'h00;
      tb2_reg      <= 8'h00;
      exc_reg      <= 1'b0;
      body_len_reg <= 8'h00;
      pos_reg      <= 8'h00;
      cur_reg      <= 8'h00;
      tnib_reg     <= 1'b0;
      tcrc_reg     <= serial_slave_pkg::CRC_INIT;
      tlrc_reg     <= 8'h00;
    end else begin
      case (tx_st_reg)
        T_IDLE: begin
          if (reply_go) begin
            taddr_reg    <= addr_reg;
            exc_reg      <= !(fn_ok && val_ok);
            tfn_reg      <= (fn_ok && val_ok) ? fn_reg : (fn_reg | serial_slave_pkg::EXC_FLAG);
            tb2_reg      <= !fn_ok ? serial_slave_pkg::EXC_BAD_FN : !val_ok ? serial_slave_pkg::EXC_BAD_VAL : byte_cnt;
            body_len_reg <= (fn_ok && val_ok) ? serial_slave_pkg::REPLY_HDR + byte_cnt : serial_slave_pkg::REPLY_HDR;
            pos_reg      <= 8'h00;
            tnib_reg     <= 1'b0;
            tcrc_reg     <= serial_slave_pkg::CRC_INIT;
            tlrc_reg     <= 8'h00;
            tx_st_reg    <= ascii_mode ? T_COLON : T_LOAD;
          end
        end
        T_COLON: if (push) tx_st_reg <= T_LOAD;
        T_LOAD: begin
          if (load_done) begin
            tx_st_reg <= ascii_mode ? T_CR : T_GAP;
          end else if (load_ok) begin
            cur_reg   <= load_byte;
            pos_reg   <= pos_reg + 8'h01;
            tx_st_reg <= T_SEND;
            if (in_body) begin
              tcrc_reg <= crc_upd(tcrc_reg, load_byte);
              tlrc_reg <= tlrc_reg + load_byte;
            end
          end
        end
        T_SEND: begin
          if (push) begin
            tnib_reg  <= ascii_mode && !tnib_reg;
            tx_st_reg <= (ascii_mode && !tnib_reg) ? T_SEND : T_LOAD;
          end
        end
        T_CR: if (push) tx_st_reg <= T_LF;
        T_LF: if (push) tx_st_reg <= T_IDLE;
        // counted from the last hand-off, so the gap also covers the final char in the serialiser
        T_GAP: if (quiet_done && !tx_valid) tx_st_reg <= T_IDLE;
        default: tx_st_reg <= T_IDLE;
      endcase
    end
  end

  // output holding register and line silence counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
      quiet_reg <= 24'h000000;
    end else begin
      if (push) begin
        tx_valid <= 1'b1;
        tx_data  <= tx_chr;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
      if (rx_valid || push) quiet_reg <= 24'h000000;
      else if (quiet_reg != 24'hFFFFFF) quiet_reg <= quiet_reg + 24'h000001;
    end
  end

  // checks
  property p_bcast_silent;
    @(posedge clk) disable iff (sys_rst) (frame_ok && is_bcast) |=> !tx_busy [*3];
  endproperty
  a_bcast_silent: assert property (p_bcast_silent) else $error("broadcast answered");
  property p_solicited;
    @(posedge clk) disable iff (sys_rst) $rose(tx_busy) |-> $past(good) && !$past(is_bcast);
  endproperty
  a_solicited: assert property (p_solicited) else $error("unsolicited transmit");
  property p_drop;
    @(posedge clk) disable iff (sys_rst) (frame_end && !frame_ok && !tx_busy) |=> !tx_busy && rx_drop;
  endproperty
  a_drop: assert property (p_drop) else $error("bad frame not dropped");
  property p_own_addr;
    @(posedge clk) disable iff (sys_rst) $rose(tx_busy) |-> taddr_reg == own_addr && own_addr >= 8'h01 && own_addr <= 8'hF7;
  endproperty
  a_own_addr: assert property (p_own_addr) else $error("reply to foreign address");
  property p_exception;
    @(posedge clk) disable iff (sys_rst) (reply_go && !fn_ok) |=> exc_reg && tfn_reg[7] && tb2_reg == 8'h01;
  endproperty
  a_exception: assert property (p_exception) else $error("no exception for bad function");
  property p_read_fn;
    @(posedge clk) disable iff (sys_rst) q_valid |-> q_func >= 8'h01 && q_func <= 8'h04 && q_count != 16'h0000;
  endproperty
  a_read_fn: assert property (p_read_fn) else $error("unsupported function dispatched");
  property p_gap;
    @(posedge clk) disable iff (sys_rst) (tx_st_reg == T_GAP && !ascii_mode) ##1 !tx_busy |-> $past(quiet_reg) >= gap_cycles;
  endproperty
  a_gap: assert property (p_gap) else $error("reply gap too short");
  property p_char_end;
    @(posedge clk) disable iff (sys_rst) (ascii_mode && frame_end) |-> rx_valid && rx_data == 8'h0A;
  endproperty
  a_char_end: assert property (p_char_end) else $error("character frame ended without terminator");
  property p_start_addr;
    @(posedge clk) disable iff (sys_rst) (push && tx_st_reg == T_SEND && pos_reg == 8'h01 && !ascii_mode)
      |=> tx_data == taddr_reg;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("reply does not open with address");
  c_normal: cover property (@(posedge clk) disable iff (sys_rst) reply_go && fn_ok && val_ok);
  c_exc: cover property (@(posedge clk) disable iff (sys_rst) reply_go && !fn_ok);
  c_bcast: cover property (@(posedge clk) disable iff (sys_rst) act && is_bcast);
  c_drop: cover property (@(posedge clk) disable iff (sys_rst) rx_drop);
endmodule

// ### serial_slave_pkg.sv
// constants for the serial slave message framer
package serial_slave_pkg;
  localparam logic [7:0]  BCAST_ADDR   = 8'h00;
  localparam logic [7:0]  ADDR_MAX     = 8'hF7;
  localparam logic [7:0]  FN_MIN       = 8'h01;
  localparam logic [7:0]  FN_BIT_MAX   = 8'h02;  // codes up to this one read single bits
  localparam logic [7:0]  FN_MAX       = 8'h04;
  localparam logic [7:0]  EXC_FLAG     = 8'h80;
  localparam logic [7:0]  EXC_BAD_FN   = 8'h01;
  localparam logic [7:0]  EXC_BAD_VAL  = 8'h03;
  localparam logic [15:0] MAX_REGS     = 16'h007D;
  localparam logic [15:0] MAX_BITS     = 16'h07D0;
  localparam logic [7:0]  CHR_START    = 8'h3A;
  localparam logic [7:0]  CHR_CR       = 8'h0D;
  localparam logic [7:0]  CHR_LF       = 8'h0A;
  localparam logic [7:0]  ASC_ZERO     = 8'h30;
  localparam logic [7:0]  ASC_NINE     = 8'h39;
  localparam logic [7:0]  ASC_UA       = 8'h41;
  localparam logic [7:0]  ASC_UF       = 8'h46;
  localparam logic [7:0]  ASC_A_OFS    = 8'h37;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'hA001;
  localparam logic [7:0]  MIN_LEN_BIN  = 8'h04;
  localparam logic [7:0]  MIN_LEN_CHR  = 8'h03;
  localparam logic [7:0]  READ_LEN_BIN = 8'h08;
  localparam logic [7:0]  READ_LEN_CHR = 8'h07;
  localparam logic [7:0]  LEN_MAX      = 8'hFF;
  localparam logic [7:0]  REPLY_HDR    = 8'h03;
  localparam int          BITS_PER_CHAR  = 11;
  localparam int          GAP_HALF_CHARS = 7;   // 3.5 character times
  localparam logic [23:0] GAP_FACTOR   = 24'(BITS_PER_CHAR * GAP_HALF_CHARS);
endpackage

// ### master_model.sv
// polling master model: sends query characters and takes reply characters
`timescale 1ns/1ns
module master_model (
  input  wire logic       clk,
  input  wire logic       slow,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rx_err,
  output logic            tx_ready
);
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    rx_err   = 1'b0;
    tx_ready = 1'b0;
  end
  // a slow master takes every other cycle, so each reply character has to wait
  always @(negedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // only the master starts traffic; the line shows junk afterwards, never the old value
  task automatic send_char(input logic [7:0] c, input logic err);
    @(negedge clk);
    rx_data  <= c;
    rx_valid <= 1'b1;
    rx_err   <= err;
    @(negedge clk);
    rx_data  <= ~c;
    rx_valid <= 1'b0;
    rx_err   <= 1'b0;
  endtask
endmodule

// ### serial_slave_framer_tb_top.sv
// self-checking bench for the serial slave framer
`timescale 1ns/1ns
module serial_slave_framer_tb_top;
  typedef logic [7:0] bq_t[$];
  localparam int GAP = 154;  // 4 clocks a bit, 77/2 bit times
  logic        clk, sys_rst, ascii_mode, slow, rx_valid, rx_err, tx_valid, tx_ready;
  logic        q_valid, q_bcast, data_valid, data_ready, rx_drop, tx_busy;
  logic [7:0]  own_addr, rx_data, tx_data, q_func, data_byte;
  logic [15:0] bit_cycles, q_start, q_count, lfsr;
  logic [40:0] exp_q[$];
  bq_t         exp_tx, dq;
  int          exp_drop, errors, n_tests, quiet;

  serial_slave_framer serial_slave_framer_i (.clk(clk), .sys_rst(sys_rst), .ascii_mode(ascii_mode),
    .own_addr(own_addr), .bit_cycles(bit_cycles), .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .q_valid(q_valid), .q_bcast(q_bcast),
    .q_func(q_func), .q_start(q_start), .q_count(q_count), .data_byte(data_byte), .data_valid(data_valid),
    .data_ready(data_ready), .rx_drop(rx_drop), .tx_busy(tx_busy));
  master_model master_model_i (.clk(clk), .slow(slow), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_err(rx_err), .tx_ready(tx_ready));

  always #25 clk = ~clk;

  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  // frame bytes in the mode chr selects: cyclic check low first, or hex text with negated sum
  function automatic bq_t encode(input bq_t b, input logic chr);
    bq_t         o;
    logic [15:0] c;
    logic [7:0]  s;
    s = 8'h00;
    c = serial_slave_pkg::CRC_INIT;
    if (!chr) begin
      foreach (b[i]) begin
        c = c ^ {8'h00, b[i]};
        for (int k = 0; k < 8; k++)
          c = c[0] ? (c >> 1) ^ serial_slave_pkg::CRC_POLY : c >> 1;
      end
      o = {b, c[7:0], c[15:8]};
      return o;
    end
    foreach (b[i]) s = s + b[i];
    b.push_back(8'h00 - s);
    o.push_back(serial_slave_pkg::CHR_START);
    foreach (b[i]) o = {o, hx(b[i][7:4]), hx(b[i][3:0])};
    o = {o, serial_slave_pkg::CHR_CR, serial_slave_pkg::CHR_LF};
    return o;
  endfunction

  task automatic miss(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) miss($sformatf("reply char %h, expected %h", g, e));
  endtask
  task automatic cmp_q(input logic [40:0] g, input logic [40:0] e);
    n_tests++;
    if (g !== e) miss($sformatf("query report %h, expected %h", g, e));
  endtask
  task automatic cmp1(input logic g, input logic e);
    n_tests++;
    if (g !== e) miss("flag check failed");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // note what the slave must do with one query, then send it through the master
  task automatic query(input logic [7:0] a, input logic [7:0] f, input logic [15:0] cnt, input logic chr,
                       input logic bad, input logic err);
    bq_t         b, r, o;
    logic [15:0] st;
    logic        bad_fn, bad_val;
    int          n;
    lfsr = nxt(lfsr);
    st = lfsr;
    b = '{a, f, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
    n = (f <= serial_slave_pkg::FN_BIT_MAX) ? (int'(cnt) + 7) / 8 : 2 * int'(cnt);
    bad_fn = f < serial_slave_pkg::FN_MIN || f > serial_slave_pkg::FN_MAX;
    bad_val = cnt == 16'h0000 || cnt > ((f <= serial_slave_pkg::FN_BIT_MAX) ? serial_slave_pkg::MAX_BITS
                                                                                : serial_slave_pkg::MAX_REGS);
    // a text frame seen in binary mode is only a run of bytes with a bad cyclic check: dropped, never answered
    if (chr != ascii_mode) exp_drop += int'(!ascii_mode);
    else if (bad || err) exp_drop++;
    else if (a == own_addr || a == serial_slave_pkg::BCAST_ADDR) begin
      if (bad_fn || bad_val) begin
        r = '{a, f | serial_slave_pkg::EXC_FLAG, bad_fn ? 8'h01 : 8'h03};
        if (a != 8'h00) exp_tx = {exp_tx, encode(r, chr)};
      end else begin
        exp_q.push_back({a == 8'h00, f, st, cnt});
        r = '{a, f, 8'(n)};
        for (int i = 0; i < n && a != 8'h00; i++) begin
          lfsr = nxt(lfsr);
          dq.push_back(lfsr[7:0]);
          r.push_back(lfsr[7:0]);
        end
        if (a != 8'h00) exp_tx = {exp_tx, encode(r, chr)};
      end
    end
    o = encode(b, chr);
    if (bad) o[o.size() - (chr ? 3 : 2)] ^= 8'h01;
    foreach (o[i]) master_model_i.send_char(o[i], err && i == 2);
  endtask

  // wait out the silence, then for every noted result, under a bound
  task automatic settle(input string name);
    int t;
    if (!ascii_mode) repeat (GAP + 2) @(negedge clk);
    repeat (4) @(negedge clk);
    for (t = 0; t < 4000 && (exp_tx.size() || exp_q.size() || exp_drop || tx_busy !== 1'b0); t++)
      @(negedge clk);
    if (t == 4000) begin
      miss({"no complete answer in ", name});
      wrap_up();
    end
    $display("test %s finished", name);
  endtask

  // reply data offered at the falling edge from the noted queue
  always @(negedge clk) begin
    data_valid <= dq.size() > 0;
    data_byte <= dq.size() ? dq[0] : ~data_byte;
  end
  // watcher: every result pops the oldest note
  always @(posedge clk) begin
    quiet <= rx_valid ? 0 : quiet + 1;
    if (data_valid && data_ready) void'(dq.pop_front());
    if (tx_valid && tx_ready) begin
      if (exp_tx.size() == 0) miss("unexpected reply char");
      else cmp8(tx_data, exp_tx.pop_front());
    end
    if (q_valid) begin
      cmp1(ascii_mode || quiet >= GAP - 1, 1'b1);
      if (exp_q.size() == 0) miss("unexpected query report");
      else cmp_q({q_bcast, q_func, q_start, q_count}, exp_q.pop_front());
    end
    if (rx_drop) begin
      cmp1(exp_drop > 0, 1'b1);
      exp_drop--;
    end
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    ascii_mode = 1'b0;
    own_addr = 8'h11;
    bit_cycles = 16'h0004;
    slow = 1'b0;
    data_byte = 8'h00;
    data_valid = 1'b0;
    lfsr = 16'h0003;
    {exp_drop, errors, n_tests, quiet} = '0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    for (int f = 1; f <= 4; f++) begin
      slow = f[1];
      query(8'h11, 8'(f), f <= 2 ? 16'h0009 : 16'h0002, 1'b0, 1'b0, 1'b0);
      settle("binary read");
    end
    query(8'h11, 8'h05, 16'h0001, 1'b0, 1'b0, 1'b0);
    settle("bad function");
    query(8'h11, 8'h03, 16'h0000, 1'b0, 1'b0, 1'b0);
    settle("zero count");
    query(8'h11, 8'h01, 16'h07D1, 1'b0, 1'b0, 1'b0);
    settle("count too large");
    query(8'h11, 8'h03, 16'h0001, 1'b0, 1'b1, 1'b0);
    settle("bad cyclic check");
    query(8'h11, 8'h04, 16'h0001, 1'b0, 1'b0, 1'b1);
    settle("line error");
    query(8'h12, 8'h03, 16'h0001, 1'b0, 1'b0, 1'b0);
    settle("other address");
    query(8'h00, 8'h01, 16'h0008, 1'b0, 1'b0, 1'b0);
    settle("broadcast");
    query(8'h11, 8'h03, 16'h0001, 1'b1, 1'b0, 1'b0);
    settle("text frame in binary mode");
    ascii_mode = 1'b1;
    query(8'h11, 8'h03, 16'h0003, 1'b1, 1'b0, 1'b0);
    settle("text read");
    query(8'h11, 8'h02, 16'h0010, 1'b1, 1'b1, 1'b0);
    settle("bad text check");
    query(8'h11, 8'h07, 16'h0001, 1'b1, 1'b0, 1'b0);
    settle("text exception");
    wrap_up();
  end
endmodule
